/* src/adc_capture_pkg.sv */
// Constants for the converter output stage
// Notes on behaviour
// - Coding select high gives offset binary, low gives two's complement.
// - Range flag is high when the sampled input is over or under range.
// - Output sample clock is a delayed copy of the sample strobe.
// - Data and range flag change only just after the output clock falls.
// - Output disable high puts data, range flag and output clock in high impedance.
// - Tracking starts on strobe falling edge; the value is held on rising edge.
package adc_capture_pkg;
   localparam int unsigned WORD_W     = 12;
   localparam int unsigned PIPE_DEPTH = 5;
   localparam int unsigned MSB_POS    = WORD_W - 1;
   localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
endpackage : adc_capture_pkg

/* src/adc_parallel_output_capture.sv */
// Converter output stage: strobe-domain pipeline and pin drivers
`timescale 1ns/10ps
`default_nettype none
module adc_parallel_output_capture (
   // System clock and reset
   input  wire logic                            clk,
   input  wire logic                            nrst,
   // Sample strobe, also the link clock
   input  wire logic                            sample_strobe,
   // Quantiser result, offset binary, valid at strobe rise
   input  wire logic [adc_capture_pkg::WORD_W-1:0] core_code,
   input  wire logic                            core_over,
   input  wire logic                            core_under,
   // Control pins
   input  wire logic                            coding_select,
   input  wire logic                            output_disable,
   // Parallel outputs, enables high while driving
   output logic      [adc_capture_pkg::WORD_W-1:0] data_out,
   output logic                                 data_oe,
   output logic                                 range_flag,
   output logic                                 range_flag_oe,
   output logic                                 delayed_sample_clock,
   output logic                                 delayed_sample_clock_oe
);
   import adc_capture_pkg::*;

   function automatic logic [WORD_W-1:0] apply_coding(input logic [WORD_W-1:0] code, input logic offset_bin);
      apply_coding = code;
      if (!offset_bin) begin
         apply_coding[MSB_POS] = ~code[MSB_POS];
      end
   endfunction : apply_coding

   // ---------------- Strobe domain ----------------
   logic [2:0]        csel_sync_ff, nxt_csel_sync;
   logic              csel_ff, nxt_csel;
   logic [WORD_W-1:0] pipe_word_ff [PIPE_DEPTH];
   logic [WORD_W-1:0] nxt_pipe_word [PIPE_DEPTH];
   logic              pipe_rng_ff [PIPE_DEPTH];
   logic              nxt_pipe_rng [PIPE_DEPTH];
   logic [WORD_W-1:0] link_word_ff, nxt_link_word;
   logic              link_rng_ff, nxt_link_rng;
   logic              link_tgl_ff, nxt_link_tgl;
   // Strobe rises since reset; checks skip the reset contents of the pipe
   logic [2:0]        warm_cnt_ff, nxt_warm_cnt;
   logic              pipe_full;

   always_comb begin
      nxt_csel_sync = {csel_sync_ff[1:0], coding_select};
      nxt_csel      = (csel_sync_ff[1] == csel_sync_ff[2]) ? csel_sync_ff[2] : csel_ff;
      // Held value taken at strobe rise; tracking is the low half
      nxt_pipe_word[0] = core_code;
      nxt_pipe_rng[0]  = core_over | core_under;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
         nxt_pipe_word[i] = pipe_word_ff[i-1];
         nxt_pipe_rng[i]  = pipe_rng_ff[i-1];
      end
      nxt_link_word = apply_coding(pipe_word_ff[PIPE_DEPTH-1], csel_ff);
      nxt_link_rng  = pipe_rng_ff[PIPE_DEPTH-1];
      nxt_link_tgl  = ~link_tgl_ff;
      nxt_warm_cnt  = warm_cnt_ff;
      if (warm_cnt_ff != 3'(PIPE_DEPTH)) begin
         nxt_warm_cnt = warm_cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge sample_strobe or negedge nrst) begin
      if (!nrst) begin
         csel_sync_ff <= 3'h0;
         csel_ff      <= 1'h0;
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_word_ff[i] <= WORD_RST;
            pipe_rng_ff[i]  <= 1'h0;
         end
         link_word_ff <= WORD_RST;
         link_rng_ff  <= 1'h0;
         link_tgl_ff  <= 1'h0;
         warm_cnt_ff  <= 3'h0;
      end else begin
         csel_sync_ff <= nxt_csel_sync;
         csel_ff      <= nxt_csel;
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_word_ff[i] <= nxt_pipe_word[i];
            pipe_rng_ff[i]  <= nxt_pipe_rng[i];
         end
         link_word_ff <= nxt_link_word;
         link_rng_ff  <= nxt_link_rng;
         link_tgl_ff  <= nxt_link_tgl;
         warm_cnt_ff  <= nxt_warm_cnt;
      end
   end

   // ---------------- System clock domain ----------------
   // Word is stable a full strobe period after its toggle, longer than the sync delay
   logic [2:0]        tgl_sync_ff, nxt_tgl_sync;
   logic [WORD_W-1:0] held_word_ff, nxt_held_word;
   logic              held_rng_ff, nxt_held_rng;
   logic [2:0]        strb_sync_ff, nxt_strb_sync;
   logic              dclk_ff, nxt_dclk;
   logic              upd_ff, nxt_upd;
   logic [WORD_W-1:0] data_ff, nxt_data;
   logic              rng_ff, nxt_rng;
   logic [2:0]        dis_sync_ff, nxt_dis_sync;
   logic              hiz_ff, nxt_hiz;

   always_comb begin
      nxt_tgl_sync  = {tgl_sync_ff[1:0], link_tgl_ff};
      nxt_held_word = held_word_ff;
      nxt_held_rng  = held_rng_ff;
      if (tgl_sync_ff[1] != tgl_sync_ff[2]) begin
         nxt_held_word = link_word_ff;
         nxt_held_rng  = link_rng_ff;
      end
      nxt_strb_sync = {strb_sync_ff[1:0], sample_strobe};
      // Filtered copy of the strobe drives the output clock
      nxt_dclk = (strb_sync_ff[1] == strb_sync_ff[2]) ? strb_sync_ff[2] : dclk_ff;
      nxt_upd  = dclk_ff & ~nxt_dclk;
      nxt_data = data_ff;
      nxt_rng  = rng_ff;
      if (upd_ff) begin
         nxt_data = held_word_ff;
         nxt_rng  = held_rng_ff;
      end
      nxt_dis_sync = {dis_sync_ff[1:0], output_disable};
      nxt_hiz      = (dis_sync_ff[1] == dis_sync_ff[2]) ? dis_sync_ff[2] : hiz_ff;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tgl_sync_ff  <= 3'h0;
         held_word_ff <= WORD_RST;
         held_rng_ff  <= 1'h0;
         strb_sync_ff <= 3'h0;
         dclk_ff      <= 1'h0;
         upd_ff       <= 1'h0;
         data_ff      <= WORD_RST;
         rng_ff       <= 1'h0;
         dis_sync_ff  <= 3'h0;
         hiz_ff       <= 1'h0;
      end else begin
         tgl_sync_ff  <= nxt_tgl_sync;
         held_word_ff <= nxt_held_word;
         held_rng_ff  <= nxt_held_rng;
         strb_sync_ff <= nxt_strb_sync;
         dclk_ff      <= nxt_dclk;
         upd_ff       <= nxt_upd;
         data_ff      <= nxt_data;
         rng_ff       <= nxt_rng;
         dis_sync_ff  <= nxt_dis_sync;
         hiz_ff       <= nxt_hiz;
      end
   end

   assign data_out                = data_ff;
   assign range_flag              = rng_ff;
   assign delayed_sample_clock    = dclk_ff;
   // Slow filter is fine: disable is meant for long idle periods only
   assign data_oe                 = ~hiz_ff;
   assign range_flag_oe           = ~hiz_ff;
   assign delayed_sample_clock_oe = ~hiz_ff;

   // ---------------- Assertions ----------------
   // Only the checks read this; past values from reset time are not samples
   assign pipe_full = (warm_cnt_ff == 3'(PIPE_DEPTH));

   sequence s_dclk_fell;
      dclk_ff ##1 !dclk_ff;
   endsequence

   sequence s_dis_released;
      !dis_sync_ff[1] && !dis_sync_ff[2];
   endsequence

   AST_CODING: assert property (@(posedge sample_strobe) disable iff (!nrst)
      pipe_full |-> link_word_ff[MSB_POS] == ($past(pipe_word_ff[PIPE_DEPTH-1][MSB_POS]) ^ !$past(csel_ff)))
      else $error("output coding does not follow coding select");

   AST_RANGE: assert property (@(posedge sample_strobe) disable iff (!nrst)
      pipe_full |-> pipe_rng_ff[0] == ($past(core_over) | $past(core_under)))
      else $error("range flag does not reflect over or under range");

   AST_HOLD: assert property (@(posedge sample_strobe) disable iff (!nrst)
      pipe_full |-> ##1 pipe_word_ff[PIPE_DEPTH-1] == $past(core_code, PIPE_DEPTH))
      else $error("held word not taken at strobe rise");

   AST_RANGE_HOLD: assert property (@(posedge sample_strobe) disable iff (!nrst)
      pipe_full |-> ##1 pipe_rng_ff[PIPE_DEPTH-1] == ($past(core_over, PIPE_DEPTH) | $past(core_under, PIPE_DEPTH)))
      else $error("range flag lost its sample on the way through");

   AST_DCLK_FOLLOW: assert property (@(posedge clk) disable iff (!nrst)
      (strb_sync_ff[1] && strb_sync_ff[2]) |=> dclk_ff)
      else $error("output clock does not follow the strobe");

   AST_DCLK_LOW: assert property (@(posedge clk) disable iff (!nrst)
      (!strb_sync_ff[1] && !strb_sync_ff[2]) |=> !dclk_ff)
      else $error("output clock stays high after strobe low");

   AST_UPD_AFTER_FALL: assert property (@(posedge clk) disable iff (!nrst)
      s_dclk_fell |-> upd_ff ##1 (data_ff == $past(held_word_ff)))
      else $error("data not updated just after output clock fall");

   AST_UPD_ONCE: assert property (@(posedge clk) disable iff (!nrst)
      upd_ff |=> !upd_ff)
      else $error("more than one update per output clock fall");

   // Capture side latches on the rise, so the word must sit still while high
   AST_DATA_QUIET: assert property (@(posedge clk) disable iff (!nrst)
      dclk_ff |-> $stable(data_ff) && $stable(rng_ff))
      else $error("data moved while the output clock was high");

   AST_HELD_TAKE: assert property (@(posedge clk) disable iff (!nrst)
      (tgl_sync_ff[1] != tgl_sync_ff[2]) |=> (held_word_ff == $past(link_word_ff)) && (held_rng_ff == $past(link_rng_ff)))
      else $error("crossed record not taken after the toggle");

   AST_DATA_STABLE: assert property (@(posedge clk) disable iff (!nrst)
      ($changed(data_ff) || $changed(rng_ff)) |-> !dclk_ff && !$past(dclk_ff) && $past(dclk_ff, 3))
      else $error("data changed outside the falling-edge window");

   AST_HIZ: assert property (@(posedge clk) disable iff (!nrst)
      (dis_sync_ff[1] && dis_sync_ff[2]) |=> !data_oe && !range_flag_oe && !delayed_sample_clock_oe)
      else $error("outputs driven while disabled");

   AST_OE_ON: assert property (@(posedge clk) disable iff (!nrst)
      s_dis_released |=> data_oe && range_flag_oe && delayed_sample_clock_oe)
      else $error("outputs not driven after disable released");
endmodule : adc_parallel_output_capture
`default_nettype wire

/* tb/adc_capture_sink.sv */
// Capture logic model latching one record per output clock rise while the pins are driven
`timescale 1ns/10ps
`default_nettype none
module adc_capture_sink (
   // Converter pins
   input  wire logic [adc_capture_pkg::WORD_W-1:0] data_out,
   input  wire logic                               data_oe,
   input  wire logic                               range_flag,
   input  wire logic                               delayed_sample_clock,
   input  wire logic                               delayed_sample_clock_oe,
   // Captured record
   output var logic  [adc_capture_pkg::WORD_W-1:0] word_ff,
   output var logic                                flag_ff,
   output var int                                  count_ff
);
   import adc_capture_pkg::*;
   // Floating pins must not count, so edges are ignored while disabled
   initial begin
      count_ff = 0;
      forever begin
         @(posedge delayed_sample_clock);
         if (delayed_sample_clock_oe && data_oe) begin
            word_ff  <= data_out;
            flag_ff  <= range_flag;
            count_ff <= count_ff + 1;
         end
      end
   end
endmodule : adc_capture_sink
`default_nettype wire

/* tb/adc_parallel_output_capture_tb_top.sv */
// Testbench for the converter output stage
`timescale 1ns/10ps
`default_nettype none
module adc_parallel_output_capture_tb_top;
   import adc_capture_pkg::*;
   logic              clk = 1'b0, nrst = 1'b0, strobe = 1'b0, sel = 1'b1, dis = 1'b0;
   logic [WORD_W-1:0] code = 12'h000, data_out, word;
   logic              ovr = 1'b0, und = 1'b0, data_oe, flag_out, flag_oe, dclk, dclk_oe, flag;
   int                count, n0, bad_count = 0, checked = 0;
   always #5 clk = ~clk;
   // Link clock: 64 ns period, 32 ns halves, phase unrelated to clk
   initial #3.5 forever #32 strobe = ~strobe;
   adc_parallel_output_capture i_dut (.clk(clk), .nrst(nrst), .sample_strobe(strobe), .core_code(code),
      .core_over(ovr), .core_under(und), .coding_select(sel), .output_disable(dis), .data_out(data_out),
      .data_oe(data_oe), .range_flag(flag_out), .range_flag_oe(flag_oe), .delayed_sample_clock(dclk),
      .delayed_sample_clock_oe(dclk_oe));
   adc_capture_sink i_sink (.data_out(data_out), .data_oe(data_oe), .range_flag(flag_out),
      .delayed_sample_clock(dclk), .delayed_sample_clock_oe(dclk_oe), .word_ff(word), .flag_ff(flag),
      .count_ff(count));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // Long settle covers the selector filter plus pipeline depth
   task automatic coding_case(input logic s, input logic [11:0] c, input logic o, input logic u);
      @(posedge clk);
      #1;
      sel = s;
      code = c;
      ovr = o;
      und = u;
      repeat (14) @(posedge dclk);
      #1;
      check("word", {4'h0, word}, {4'h0, s ? c : c ^ 12'h800});
      check("flag", {15'h0, flag}, {15'h0, o | u});
   endtask : coding_case
   task automatic follow_case;
      @(posedge strobe);
      n0 = count;
      repeat (10) @(posedge strobe);
      check("output clock rises", 16'(count - n0), 16'd10);
   endtask : follow_case
   task automatic disable_case;
      @(posedge clk);
      #1 dis = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check("enables off", {13'h0, data_oe, flag_oe, dclk_oe}, 16'h0);
      n0 = count;
      repeat (4) @(posedge strobe);
      check("records while off", 16'(count - n0), 16'd0);
      @(posedge clk);
      #1 dis = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check("enables on", {13'h0, data_oe, flag_oe, dclk_oe}, 16'h7);
   endtask : disable_case
   initial begin
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      coding_case(1'b1, 12'hfff, 1'b1, 1'b0);
      coding_case(1'b0, 12'hfff, 1'b0, 1'b0);
      coding_case(1'b0, 12'h000, 1'b0, 1'b1);
      coding_case(1'b1, 12'h5a3, 1'b0, 1'b0);
      follow_case();
      disable_case();
      coding_case(1'b0, 12'h7ff, 1'b1, 1'b1);
      close_out();
   end
   // Whole run needs about 6 us
   initial begin
      #50000;
      bad_count++;
      close_out();
   end
endmodule : adc_parallel_output_capture_tb_top
`default_nettype wire
